// ### design/dssw_pkg.sv
// Constants and carrier types for the drive state status word block.
// Assumes a single 200 MHz clock and a synchronous active-high reset.
//
// Overview of operation
// - No-fault in 4,5,6; active only in 6.
// - Read-only 16-bit status word, reset zero, address 6916.
// - States 2,3 clear bits 0-3; 3 sets 6.
// - States 4-6 set bits 5,0; add 1, 2.
// - Quick stop reports bits 0-2 set only.
// - Fault states set bits 0-3, clear 6.
// - Bit 4 shows bus voltage; blocks 3 to 4.
// - Fault reset clears warning bit immediately.
// - Bit 8 follows active halt.
// - Bit 9 shows fieldbus control; reads allowed whenever ce_i is high.
// - Bit 12 carries mode-specific monitoring.
// - Bit 13 flags errors needing remedy.
// - Bit 14 drops on start, rises at standstill.
// - Suppress bit 14 rise on mode change.
// - Bit 15 shows valid reference point.
package dssw_pkg;

	localparam logic [15:0] DSSW_STATUS_ADDR = 16'h1b04;
	localparam logic [15:0] DSSW_STATUS_RST  = 16'h0000;

	localparam int BIT_RDY   = 0;
	localparam int BIT_SWON  = 1;
	localparam int BIT_OPEN  = 2;
	localparam int BIT_FAULT = 3;
	localparam int BIT_VOLT  = 4;
	localparam int BIT_QSTOP = 5;
	localparam int BIT_SODIS = 6;
	localparam int BIT_WARN  = 7;
	localparam int BIT_HALT  = 8;
	localparam int BIT_REM   = 9;
	localparam int BIT_TREACH = 10;
	localparam int BIT_RSVD  = 11;
	localparam int BIT_MODE  = 12;
	localparam int BIT_ERR   = 13;
	localparam int BIT_END   = 14;
	localparam int BIT_REF   = 15;

	localparam int CLK_MHZ      = 200;
	localparam int WARN_HOLD_MS = 100;
	localparam int WARN_HOLD_CYC = WARN_HOLD_MS * 1000 * CLK_MHZ;

	typedef enum logic [3:0] {
		DSSW_ST_NRDY  = 4'h2,
		DSSW_ST_SODIS = 4'h3,
		DSSW_ST_RDY   = 4'h4,
		DSSW_ST_SWON  = 4'h5,
		DSSW_ST_OPEN  = 4'h6,
		DSSW_ST_QSTOP = 4'h7,
		DSSW_ST_FREAC = 4'h8,
		DSSW_ST_FAULT = 4'h9
	} dssw_state_t;

	typedef struct packed {
		logic volt_ok;
		logic warn_any;
		logic fault_reset;
		logic halt;
		logic remote;
		logic mode_start;
		logic mode_done_ok;
		logic mode_abort;
		logic standstill;
		logic next_mode_pend;
		logic mode_mon;
		logic err_remedy;
		logic ref_ok;
	} dssw_ev_t;

	typedef struct packed {
		logic        nofault;
		logic        active;
	} dssw_sig_t;

	typedef struct packed {
		logic [15:0] status;
		logic [31:0] warn_cnt;
		logic        running;
		logic        treach;
		logic        end_flag;
		dssw_sig_t   sig;
		logic [15:0] rdata;
	} dssw_reg_t;

endpackage

// ### design/dssw_status.sv
// Drive state status word: builds the 16-bit status word and two state outputs.
// Assumes the drive's state machine and motion logic supply state and events synchronously.
module dssw_status
	import dssw_pkg::*;
#(
	parameter int WARN_HOLD = WARN_HOLD_CYC
) (
	// Clock, reset and enable.
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	// Drive state and events.
	input  wire dssw_state_t state_i,
	input  wire dssw_ev_t    ev_i,
	// State advance request from the state machine.
	input  wire logic        adv_3_4_req_i,
	output logic             adv_3_4_ok_o,
	// Parameter read port.
	input  wire logic        rd_i,
	input  wire logic [15:0] addr_i,
	output logic [15:0]      rdata_o,
	output logic             rack_o,
	// Signal outputs.
	output dssw_sig_t        sig_o
);

	dssw_reg_t state_ff;
	dssw_reg_t nxt_state;
	logic [5:0] st_bits;
	logic       warn_hold;

	always_comb begin
		unique case (state_i)
			DSSW_ST_NRDY:  st_bits = 6'b000000;
			DSSW_ST_SODIS: st_bits = 6'b100000;
			DSSW_ST_RDY:   st_bits = 6'b010001;
			DSSW_ST_SWON:  st_bits = 6'b010011;
			DSSW_ST_OPEN:  st_bits = 6'b010111;
			DSSW_ST_QSTOP: st_bits = 6'b000111;
			DSSW_ST_FREAC: st_bits = 6'b001111;
			DSSW_ST_FAULT: st_bits = 6'b001111;
			default:       st_bits = 6'b000000;
		endcase
	end

	assign warn_hold = (state_ff.warn_cnt != 32'h0);
	assign adv_3_4_ok_o = adv_3_4_req_i && ev_i.volt_ok;

	always_comb begin
		nxt_state = state_ff;
		if (ev_i.fault_reset) begin
			nxt_state.warn_cnt = 32'h0;
		end else if (ev_i.warn_any) begin
			nxt_state.warn_cnt = 32'(WARN_HOLD);
		end else if (warn_hold) begin
			nxt_state.warn_cnt = state_ff.warn_cnt - 32'h1;
		end
		if (ev_i.mode_start || ev_i.mode_abort || ev_i.halt) begin
			nxt_state.treach = 1'b0;
		end else if (ev_i.mode_done_ok && ev_i.standstill) begin
			nxt_state.treach = 1'b1;
		end
		if (ev_i.mode_start) begin
			nxt_state.running  = 1'b1;
			nxt_state.end_flag = 1'b0;
		end else if (state_ff.running && ev_i.standstill && !ev_i.next_mode_pend) begin
			nxt_state.running  = 1'b0;
			nxt_state.end_flag = 1'b1;
		end
		nxt_state.status = DSSW_STATUS_RST;
		nxt_state.status[BIT_RDY]   = st_bits[0];
		nxt_state.status[BIT_SWON]  = st_bits[1];
		nxt_state.status[BIT_OPEN]  = st_bits[2];
		nxt_state.status[BIT_FAULT] = st_bits[3];
		nxt_state.status[BIT_QSTOP] = st_bits[4];
		nxt_state.status[BIT_SODIS] = st_bits[5];
		nxt_state.status[BIT_VOLT]  = ev_i.volt_ok;
		nxt_state.status[BIT_WARN]  = !ev_i.fault_reset && (ev_i.warn_any || warn_hold);
		nxt_state.status[BIT_HALT]  = ev_i.halt;
		nxt_state.status[BIT_REM]   = ev_i.remote;
		nxt_state.status[BIT_TREACH] = nxt_state.treach;
		nxt_state.status[BIT_RSVD]  = 1'b0;
		nxt_state.status[BIT_MODE]  = ev_i.mode_mon;
		nxt_state.status[BIT_ERR]   = ev_i.err_remedy;
		nxt_state.status[BIT_END]   = nxt_state.end_flag;
		nxt_state.status[BIT_REF]   = ev_i.ref_ok;
		nxt_state.sig.nofault = (state_i == DSSW_ST_RDY) || (state_i == DSSW_ST_SWON) || (state_i == DSSW_ST_OPEN);
		nxt_state.sig.active  = (state_i == DSSW_ST_OPEN);
		if (rd_i) begin
			nxt_state.rdata = (addr_i == DSSW_STATUS_ADDR) ? state_ff.status : 16'h0000;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_ff <= '0;
		end else if (ce_i) begin
			state_ff <= nxt_state;
		end
	end

	assign rdata_o = state_ff.rdata;
	assign rack_o  = rd_i && ce_i;
	assign sig_o   = state_ff.sig;

	active_only6_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && !rst_i |=> (sig_o.active == ($past(state_i) == DSSW_ST_OPEN)))
		else $error("active output wrong for state");

	active_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && !rst_i && state_i != DSSW_ST_OPEN |=> !sig_o.active)
		else $error("active output set outside operation");

	nofault_map_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && !rst_i && state_i == DSSW_ST_FAULT |=> !sig_o.nofault)
		else $error("no-fault output set in fault");

	nofault_on_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && !rst_i && state_i inside {DSSW_ST_RDY, DSSW_ST_SWON, DSSW_ST_OPEN} |=> sig_o.nofault)
		else $error("no-fault output clear when ready");

	nofault_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && !rst_i && !(state_i inside {DSSW_ST_RDY, DSSW_ST_SWON, DSSW_ST_OPEN}) |=> !sig_o.nofault)
		else $error("no-fault output set when not ready");

	nrdy_bits_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && !rst_i && state_i == DSSW_ST_NRDY |=> state_ff.status[3:0] == 4'h0 && !state_ff.status[6])
		else $error("not ready bits wrong");

	sodis_bits_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && !rst_i && state_i == DSSW_ST_SODIS |=> state_ff.status[3:0] == 4'h0 && state_ff.status[6])
		else $error("switch on disabled bits wrong");

	rdy_bits_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && !rst_i && state_i == DSSW_ST_RDY |=> state_ff.status[6:0] ==? 7'b01x0001)
		else $error("ready bits wrong");

	swon_bits_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && !rst_i && state_i == DSSW_ST_SWON |=> state_ff.status[6:0] ==? 7'b01x0011)
		else $error("switched on bits wrong");

	open_bits_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && !rst_i && state_i == DSSW_ST_OPEN |=> state_ff.status[6:0] ==? 7'b01x0111)
		else $error("operation enable bits wrong");

	qstop_bits_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && !rst_i && state_i == DSSW_ST_QSTOP |=> state_ff.status[6:0] ==? 7'b00x0111)
		else $error("quick stop bits wrong");

	fault_bits_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && !rst_i && state_i == DSSW_ST_FAULT |=> state_ff.status[3:0] == 4'hf && !state_ff.status[6])
		else $error("fault bits wrong");

	freac_bits_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && !rst_i && state_i == DSSW_ST_FREAC |=> state_ff.status[3:0] == 4'hf && !state_ff.status[6])
		else $error("fault reaction bits wrong");

	volt_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!ev_i.volt_ok |-> !adv_3_4_ok_o)
		else $error("advance allowed without voltage");

	adv_pass_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ev_i.volt_ok && adv_3_4_req_i |-> adv_3_4_ok_o)
		else $error("advance refused with voltage");

	volt_bit_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && !rst_i |=> state_ff.status[BIT_VOLT] == $past(ev_i.volt_ok))
		else $error("voltage bit wrong");

	warn_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && !rst_i && ev_i.warn_any && !ev_i.fault_reset |=> state_ff.status[BIT_WARN])
		else $error("warning bit not set");

	warn_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && !rst_i && ev_i.warn_any && !ev_i.fault_reset ##1 (ce_i && !ev_i.fault_reset)[*2]
		|=> state_ff.status[BIT_WARN])
		else $error("warning released too early");

	warn_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && !rst_i && !ev_i.warn_any && state_ff.warn_cnt == 32'h0 |=> !state_ff.status[BIT_WARN])
		else $error("warning bit stuck");

	warn_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && !rst_i && ev_i.fault_reset |=> !state_ff.status[BIT_WARN])
		else $error("fault reset did not clear warning");

	halt_bit_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && !rst_i |=> state_ff.status[BIT_HALT] == $past(ev_i.halt))
		else $error("halt bit wrong");

	remote_bit_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && !rst_i |=> state_ff.status[BIT_REM] == $past(ev_i.remote))
		else $error("remote bit wrong");

	read_any_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_i && ce_i |-> rack_o)
		else $error("read not acknowledged");

	read_data_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && !rst_i && rd_i && addr_i == DSSW_STATUS_ADDR |=> rdata_o == $past(state_ff.status))
		else $error("status read data wrong");

	read_unmap_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && !rst_i && rd_i && addr_i != DSSW_STATUS_ADDR |=> rdata_o == 16'h0000)
		else $error("unmapped read not zero");

	treach_run_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && !rst_i && ev_i.mode_start |=> !state_ff.status[BIT_TREACH])
		else $error("target reached set at start");

	treach_halt_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && !rst_i && ev_i.halt |=> !state_ff.status[BIT_TREACH])
		else $error("target reached set during halt");

	treach_abort_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && !rst_i && ev_i.mode_abort |=> !state_ff.status[BIT_TREACH])
		else $error("target reached set after abort");

	mode_bit_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && !rst_i |=> state_ff.status[BIT_MODE] == $past(ev_i.mode_mon))
		else $error("mode monitor bit wrong");

	err_bit_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && !rst_i |=> state_ff.status[BIT_ERR] == $past(ev_i.err_remedy))
		else $error("error bit wrong");

	end_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && !rst_i && ev_i.mode_start |=> !state_ff.end_flag)
		else $error("end flag not cleared at start");

	end_rise_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && !rst_i && !ev_i.mode_start && state_ff.running && ev_i.standstill && !ev_i.next_mode_pend
		|=> state_ff.status[BIT_END])
		else $error("end flag not set at standstill");

	end_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && !rst_i && ev_i.next_mode_pend && !state_ff.end_flag |=> !state_ff.end_flag)
		else $error("end flag rose between chained modes");

	ref_bit_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && !rst_i |=> state_ff.status[BIT_REF] == $past(ev_i.ref_ok))
		else $error("reference bit wrong");

	rsvd_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!state_ff.status[BIT_RSVD])
		else $error("reserved bit set");

endmodule

// ### tb/dssw_master.sv
// Fieldbus master model that reads drive parameters from the status block.
// Assumes requests change on the falling edge of the shared clock.
module dssw_master (
	// Clock, read data and acknowledge.
	input  wire logic        clk_i,
	input  wire logic [15:0] rdata_i,
	input  wire logic        rack_i,
	// Read request.
	output logic             rd_o,
	output logic [15:0]      addr_o
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		rd_o = 1'b0;
		addr_o = 16'h0000;
	end
	task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic k);
		@(negedge clk_i);
		rd_o = 1'b1;
		addr_o = a;
		@(posedge clk_i);
		k = rack_i;
		@(negedge clk_i);
		rd_o = 1'b0;
		addr_o = ~a;
		d = rdata_i;
	endtask
endmodule

// ### tb/tb.sv
// Self-checking bench for the drive state status word block.
// Assumes the fieldbus master model and a short warning hold.
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin mismatches++; \
	$display("MISMATCH %s exp %h got %h", n, e, s); end end
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import dssw_pkg::*;
	logic        clk_i, rst_i, req, ok, rd, rack, ce, k;
	logic [15:0] addr, rdata, lfsr, d;
	dssw_state_t st;
	dssw_ev_t    ev;
	dssw_sig_t   sig;
	int          mismatches, n_compared;
	dssw_status #(.WARN_HOLD(8)) u_dssw_status (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .state_i(st),
		.ev_i(ev), .adv_3_4_req_i(req), .adv_3_4_ok_o(ok), .rd_i(rd), .addr_i(addr), .rdata_o(rdata),
		.rack_o(rack), .sig_o(sig));
	dssw_master u_dssw_master (.clk_i(clk_i), .rdata_i(rdata), .rack_i(rack), .rd_o(rd), .addr_o(addr));
	function automatic logic [15:0] nx(logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	// Expected word with the stateful bits 7, 10 and 14 left as zero.
	function automatic logic [15:0] exp_sw(dssw_state_t s, dssw_ev_t e);
		logic [6:0] b;
		case (s)
			DSSW_ST_NRDY: b = 7'h00;
			DSSW_ST_SODIS: b = 7'h40;
			DSSW_ST_RDY: b = 7'h21;
			DSSW_ST_SWON: b = 7'h23;
			DSSW_ST_OPEN: b = 7'h27;
			DSSW_ST_QSTOP: b = 7'h07;
			default: b = 7'h0f;
		endcase
		b[4] = e.volt_ok;
		return {e.ref_ok, 1'b0, e.err_remedy, e.mode_mon, 2'b00, e.remote, e.halt, 1'b0, b};
	endfunction
	task automatic rdchk(string n, logic [15:0] m, logic [15:0] e);
		u_dssw_master.rd(DSSW_STATUS_ADDR, d, k);
		`CHK(n, 1'b1, k)
		`CHK(n, e, d & m)
	endtask
	task automatic pulse_start();
		ev = '0;
		ev.mode_start = 1'b1;
		@(negedge clk_i);
		ev.mode_start = 1'b0;
	endtask
	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	initial begin
		#20us;
		mismatches++;
		test_done();
	end
	initial begin
		rst_i = 1'b1;
		st = DSSW_ST_NRDY;
		ev = '0;
		req = 1'b0;
		ce = 1'b1;
		lfsr = 16'h001a;
		repeat (2) @(negedge clk_i);
		rst_i = 1'b0;
		rdchk("reset", 16'hffff, DSSW_STATUS_RST);
		$display("reset done");
		for (int i = 0; i < 60; i++) begin
			lfsr = nx(lfsr);
			st = dssw_state_t'(4'h2 + {1'b0, lfsr[2:0]});
			ev = dssw_ev_t'(lfsr[15:3]);
			req = lfsr[1];
			@(negedge clk_i);
			`CHK("adv", req & ev.volt_ok, ok)
			`CHK("sig", {st inside {4'h4, 4'h5, 4'h6}, st == DSSW_ST_OPEN}, sig)
			rdchk("status", 16'hbb7f, exp_sw(st, ev));
			u_dssw_master.rd(DSSW_STATUS_ADDR + 16'h0001, d, k);
			`CHK("unmapped ack", 1'b1, k)
			`CHK("unmapped", 16'h0000, d)
		end
		$display("random states done");
		ev = '0;
		ev.warn_any = 1'b1;
		@(negedge clk_i);
		ev.warn_any = 1'b0;
		rdchk("warn hold", 16'h0080, 16'h0080);
		repeat (12) @(negedge clk_i);
		rdchk("warn end", 16'h0080, 16'h0000);
		ev.warn_any = 1'b1;
		@(negedge clk_i);
		ev.warn_any = 1'b0;
		ev.fault_reset = 1'b1;
		rdchk("fault reset", 16'h0080, 16'h0000);
		$display("warning done");
		st = DSSW_ST_OPEN;
		pulse_start();
		rdchk("start", 16'h4400, 16'h0000);
		ev.mode_done_ok = 1'b1;
		ev.standstill = 1'b1;
		rdchk("done", 16'h4400, 16'h4400);
		pulse_start();
		ev.halt = 1'b1;
		ev.standstill = 1'b1;
		rdchk("halt", 16'h4500, 16'h4100);
		pulse_start();
		ev.next_mode_pend = 1'b1;
		ev.standstill = 1'b1;
		rdchk("chained", 16'h4000, 16'h0000);
		$display("motion flags done");
		ce = 1'b0;
		st = DSSW_ST_NRDY;
		repeat (2) @(negedge clk_i);
		`CHK("freeze", 2'b11, sig)
		ce = 1'b1;
		st = DSSW_ST_OPEN;
		rst_i = 1'b1;
		@(negedge clk_i);
		`CHK("reset sig", 2'b00, sig)
		`CHK("reset rdata", DSSW_STATUS_RST, rdata)
		rst_i = 1'b0;
		$display("freeze and reset done");
		test_done();
	end
endmodule
